// file: hdl/cpps_consts.svh
`ifndef CPPS_CONSTS_SVH
`define CPPS_CONSTS_SVH
`define CPPS_PC_W 11
`define CPPS_ROM_WORDS 1920
`define CPPS_RVEC_HI 11'h000
`define CPPS_RVEC_LO 11'h001
`define CPPS_RAM_WORDS 64
`define CPPS_RAM_LIMIT 12'h040
`define CPPS_STK_TOP 3'h1
`define CPPS_SP_ADDR 12'hF80
`define CPPS_SP_RESET 8'h00
`define CPPS_ACC_LO 6'h00
`define CPPS_ACC_HI 6'h01
`define CPPS_PTR_LO 6'h02
`define CPPS_PTR_HI 6'h03
`define CPPS_REL_NEG_MIN -15
`define CPPS_REL_NEG_MAX -1
`define CPPS_REL_POS_MIN 2
`define CPPS_REL_POS_MAX 16
`define CPPS_N_CALL 3'h4
`define CPPS_N_INT 3'h6
`define CPPS_PC_SKIP 3'h2
`endif

// file: hdl/cpps_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpps_consts.svh"
module cpps_core #(
  parameter int ROM_WORDS = `CPPS_ROM_WORDS,
  parameter int RAM_WORDS = `CPPS_RAM_WORDS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // program memory load port
  input wire logic rom_load_i,
  input wire logic [10:0] rom_load_addr_i,
  input wire logic [7:0] rom_load_data_i,
  // instruction command
  input wire logic cmd_valid_i,
  input wire cpps_pkg::cpps_cmd_t cmd_i,
  // status and results
  output logic busy_o,
  output logic [10:0] program_counter_o,
  output logic [7:0] fetch_data_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic [7:0] psw_o,
  output logic psw_valid_o,
  output logic err_o,
  output logic [7:0] pointer_register_pair_o,
  output logic [7:0] accumulator_pair_o
);
  logic [7:0] rom [ROM_WORDS];
  logic [3:0] ram [RAM_WORDS];

  cpps_pkg::cpps_state_t state, next_state;
  logic [10:0] program_counter, next_program_counter;
  logic [7:0] stack_top_pointer, next_stack_top_pointer;
  logic [2:0] cnt, next_cnt;
  logic [2:0] last, next_last;
  logic [10:0] ret_pc, next_ret_pc;
  logic [10:0] tgt, next_tgt;
  logic [7:0] psw_hold, next_psw_hold;
  logic is_int, next_is_int;
  logic [7:0] rd_data, next_rd_data;
  logic rd_valid, next_rd_valid;
  logic psw_valid, next_psw_valid;
  logic err, next_err;
  logic we_lo, we_hi;
  logic [5:0] wa;
  logic [7:0] wd;

  function automatic logic [7:0] rom_rd(input logic [10:0] a);
    rom_rd = (int'(a) < ROM_WORDS) ? rom[a] : 8'h00;
  endfunction : rom_rd

  function automatic logic is_ram(input logic [11:0] a);
    is_ram = a < `CPPS_RAM_LIMIT;
  endfunction : is_ram

  function automatic logic [5:0] stk_addr(input logic [7:0] p);
    stk_addr = 6'({`CPPS_STK_TOP, p[4:0]});
  endfunction : stk_addr

  // stack nibble order, the lowest index pushed (0 for interrupts, 2 for calls) is written first and read last
  function automatic logic [3:0] push_nib(input logic [2:0] i, input logic [10:0] pc,
                                          input logic [7:0] psw);
    unique case (i)
      3'h0: push_nib = psw[7:4];
      3'h1: push_nib = psw[3:0];
      3'h2: push_nib = pc[7:4];
      3'h3: push_nib = pc[3:0];
      3'h4: push_nib = 4'h0;
      default: push_nib = {1'b0, pc[10:8]};
    endcase
  endfunction : push_nib

  logic [11:0] eff_addr;
  logic [10:0] step_pc;
  logic [10:0] rel_pc;
  logic signed [5:0] sdisp;
  logic rel_ok;
  logic [3:0] pop_nib;
  logic [2:0] push_idx;
  logic [7:0] dec_sp;
  logic [7:0] vec_hi_byte;

  always_comb begin
    eff_addr = cmd_i.use_ptr ? {4'h0, ram[`CPPS_PTR_HI], ram[`CPPS_PTR_LO]} : cmd_i.addr;
    if (cmd_i.op == cpps_pkg::OP_RD8 || cmd_i.op == cpps_pkg::OP_WR8) begin
      eff_addr[0] = 1'b0;
    end
    step_pc = program_counter + {9'h000, cmd_i.len};
    sdisp = $signed(cmd_i.disp);
    rel_pc = step_pc + {{5{cmd_i.disp[5]}}, cmd_i.disp};
    rel_ok = (sdisp >= `CPPS_REL_NEG_MIN && sdisp <= `CPPS_REL_NEG_MAX) ||
             (sdisp >= `CPPS_REL_POS_MIN && sdisp <= `CPPS_REL_POS_MAX);
    pop_nib = ram[stk_addr(stack_top_pointer)];
    push_idx = is_int ? cnt : cnt + `CPPS_PC_SKIP;
    dec_sp = stack_top_pointer - 8'h01;
    vec_hi_byte = rom_rd(`CPPS_RVEC_HI);
  end

  always_comb begin
    next_state = state;
    next_program_counter = program_counter;
    next_stack_top_pointer = stack_top_pointer;
    next_cnt = cnt;
    next_last = last;
    next_ret_pc = ret_pc;
    next_tgt = tgt;
    next_psw_hold = psw_hold;
    next_is_int = is_int;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    next_psw_valid = 1'b0;
    next_err = 1'b0;
    we_lo = 1'b0;
    we_hi = 1'b0;
    wa = 6'h00;
    wd = 8'h00;
    unique case (state)
      cpps_pkg::ST_VEC_HI: begin
        next_program_counter = {vec_hi_byte[2:0], program_counter[7:0]};
        next_state = cpps_pkg::ST_VEC_LO;
      end
      cpps_pkg::ST_VEC_LO: begin
        next_program_counter = {program_counter[10:8], rom_rd(`CPPS_RVEC_LO)};
        next_state = cpps_pkg::ST_IDLE;
      end
      cpps_pkg::ST_IDLE: begin
        if (cmd_valid_i) begin
          next_cnt = 3'h0;
          unique case (cmd_i.op)
            cpps_pkg::OP_NOP: begin
            end
            cpps_pkg::OP_STEP: next_program_counter = step_pc;
            cpps_pkg::OP_BRANCH: next_program_counter = cmd_i.target;
            cpps_pkg::OP_REL: begin
              // out-of-range displacement is flagged and treated as a plain step
              next_program_counter = rel_ok ? rel_pc : step_pc;
              next_err = !rel_ok;
            end
            cpps_pkg::OP_CALL, cpps_pkg::OP_VECTOR: begin
              next_is_int = cmd_i.op == cpps_pkg::OP_VECTOR;
              // an accepted interrupt returns to the instruction not yet run
              next_ret_pc = next_is_int ? program_counter : step_pc;
              next_tgt = cmd_i.target;
              next_psw_hold = cmd_i.psw;
              next_last = next_is_int ? `CPPS_N_INT : `CPPS_N_CALL;
              next_state = cpps_pkg::ST_PUSH;
            end
            cpps_pkg::OP_RET, cpps_pkg::OP_RET_SKIP, cpps_pkg::OP_RET_INT: begin
              next_is_int = cmd_i.op == cpps_pkg::OP_RET_INT;
              next_last = next_is_int ? `CPPS_N_INT : `CPPS_N_CALL;
              next_state = cpps_pkg::ST_POP;
            end
            cpps_pkg::OP_RD4, cpps_pkg::OP_RD8: begin
              next_program_counter = step_pc;
              if (is_ram(eff_addr)) begin
                next_rd_data = (cmd_i.op == cpps_pkg::OP_RD8) ?
                  {ram[eff_addr[5:0] | 6'h01], ram[eff_addr[5:0]]} :
                  {4'h0, ram[eff_addr[5:0]]};
                next_rd_valid = 1'b1;
              end else begin
                next_err = 1'b1;
              end
            end
            cpps_pkg::OP_WR4, cpps_pkg::OP_WR8: begin
              next_program_counter = step_pc;
              if (is_ram(eff_addr)) begin
                we_lo = 1'b1;
                we_hi = cmd_i.op == cpps_pkg::OP_WR8;
                wa = eff_addr[5:0];
                wd = cmd_i.wdata;
              end else if (eff_addr == `CPPS_SP_ADDR && cmd_i.op == cpps_pkg::OP_WR8) begin
                next_stack_top_pointer = {cmd_i.wdata[7:1], 1'b0};
              end else begin
                next_err = 1'b1;
              end
            end
            cpps_pkg::OP_TABLE: begin
              next_program_counter = step_pc;
              next_rd_data = rom_rd(cmd_i.target);
              next_rd_valid = 1'b1;
            end
            default: next_err = 1'b1;
          endcase
        end
      end
      cpps_pkg::ST_PUSH: begin
        next_stack_top_pointer = dec_sp;
        we_lo = 1'b1;
        wa = stk_addr(dec_sp);
        wd = {4'h0, push_nib(push_idx, ret_pc, psw_hold)};
        next_cnt = cnt + 3'h1;
        if (next_cnt == last) begin
          next_program_counter = tgt;
          next_state = cpps_pkg::ST_IDLE;
        end
      end
      cpps_pkg::ST_POP: begin
        next_stack_top_pointer = stack_top_pointer + 8'h01;
        unique case (cnt)
          3'h0: next_ret_pc[10:8] = pop_nib[2:0];
          3'h2: next_ret_pc[3:0] = pop_nib;
          3'h3: next_ret_pc[7:4] = pop_nib;
          3'h4: next_psw_hold[3:0] = pop_nib;
          3'h5: next_psw_hold[7:4] = pop_nib;
          default: begin
          end
        endcase
        next_cnt = cnt + 3'h1;
        if (next_cnt == last) begin
          next_program_counter = next_ret_pc;
          next_psw_valid = is_int;
          next_state = cpps_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // memories carry no reset: contents are left to the program
  always_ff @(posedge clk_i) begin
    if (rom_load_i) begin
      rom[rom_load_addr_i] <= rom_load_data_i;
    end
    if (we_lo) begin
      ram[wa] <= wd[3:0];
    end
    if (we_hi) begin
      ram[wa | 6'h01] <= wd[7:4];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= cpps_pkg::ST_VEC_HI;
      program_counter <= 11'h000;
      stack_top_pointer <= `CPPS_SP_RESET;
      cnt <= 3'h0;
      last <= 3'h0;
      ret_pc <= 11'h000;
      tgt <= 11'h000;
      psw_hold <= 8'h00;
      is_int <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      psw_valid <= 1'b0;
      err <= 1'b0;
      busy_o <= 1'b1;
      fetch_data_o <= 8'h00;
      pointer_register_pair_o <= 8'h00;
      accumulator_pair_o <= 8'h00;
    end else begin
      state <= next_state;
      program_counter <= next_program_counter;
      stack_top_pointer <= next_stack_top_pointer;
      cnt <= next_cnt;
      last <= next_last;
      ret_pc <= next_ret_pc;
      tgt <= next_tgt;
      psw_hold <= next_psw_hold;
      is_int <= next_is_int;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      psw_valid <= next_psw_valid;
      err <= next_err;
      busy_o <= next_state != cpps_pkg::ST_IDLE;
      fetch_data_o <= rom_rd(next_program_counter);
      // pair views lag RAM writes by one cycle
      pointer_register_pair_o <= {ram[`CPPS_PTR_HI], ram[`CPPS_PTR_LO]};
      accumulator_pair_o <= {ram[`CPPS_ACC_HI], ram[`CPPS_ACC_LO]};
    end
  end

  assign program_counter_o = program_counter;
  assign rd_data_o = rd_data;
  assign rd_valid_o = rd_valid;
  assign psw_o = psw_hold;
  assign psw_valid_o = psw_valid;
  assign err_o = err;
endmodule : cpps_core
`default_nettype wire

// file: hdl/cpps_pkg.sv
package cpps_pkg;
  typedef enum logic [3:0] {
    OP_NOP, OP_STEP, OP_BRANCH, OP_REL, OP_CALL, OP_VECTOR, OP_RET, OP_RET_SKIP,
    OP_RET_INT, OP_RD4, OP_WR4, OP_RD8, OP_WR8, OP_TABLE
  } cpps_op_t;
  typedef struct packed {
    cpps_op_t op;
    logic [1:0] len;
    logic [10:0] target;
    logic [5:0] disp;
    logic [11:0] addr;
    logic use_ptr;
    logic [7:0] wdata;
    logic [7:0] psw;
  } cpps_cmd_t;
  typedef enum logic [2:0] {
    ST_VEC_HI = 3'h0,
    ST_VEC_LO = 3'h1,
    ST_IDLE = 3'h3,
    ST_PUSH = 3'h2,
    ST_POP = 3'h6
  } cpps_state_t;
endpackage : cpps_pkg

// file: sim/cpps_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cpps_core_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // command side
  input wire logic cmd_valid_i,
  input wire cpps_pkg::cpps_cmd_t cmd_i,
  // results
  input wire logic busy_o,
  input wire logic [10:0] program_counter_o,
  input wire logic rd_valid_o,
  input wire logic err_o,
  input wire logic psw_valid_o,
  input wire logic [7:0] accumulator_pair_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic tk;
  cpps_pkg::cpps_op_t op;
  assign tk = cmd_valid_i && !busy_o;
  assign op = cmd_i.op;
  AST_VEC_LOAD: assert property ($fell(reset_i) |-> busy_o [*2] ##1 !busy_o)
    else $error("reset vector load length wrong");
  AST_STEP: assert property (tk && op == cpps_pkg::OP_STEP |=>
    program_counter_o == $past(program_counter_o) + $past(cmd_i.len)) else $error("step wrong");
  AST_BRANCH: assert property (tk && op == cpps_pkg::OP_BRANCH |=>
    program_counter_o == $past(cmd_i.target)) else $error("branch wrong");
  AST_CALL: assert property (tk && op == cpps_pkg::OP_CALL |=> busy_o [*4] ##1
    (!busy_o && program_counter_o == $past(cmd_i.target, 5))) else $error("call wrong");
  AST_RET: assert property (tk && (op == cpps_pkg::OP_RET || op == cpps_pkg::OP_RET_SKIP) |=>
    busy_o [*4] ##1 !busy_o) else $error("return length wrong");
  AST_INT_RET: assert property (tk && op == cpps_pkg::OP_RET_INT |=> busy_o [*6] ##1
    (!busy_o && psw_valid_o)) else $error("status restore wrong");
  AST_RD_SRC: assert property (rd_valid_o |-> $past(tk) && $past(op) inside
    {cpps_pkg::OP_RD4, cpps_pkg::OP_RD8, cpps_pkg::OP_TABLE}) else $error("stray read pulse");
  AST_UNMAPPED: assert property (tk && op == cpps_pkg::OP_RD4 && !cmd_i.use_ptr &&
    cmd_i.addr >= 12'h040 |=> err_o && !rd_valid_o) else $error("refused read passed");
  AST_ACC_PAIR: assert property (tk && op == cpps_pkg::OP_WR8 && !cmd_i.use_ptr &&
    cmd_i.addr[11:1] == 11'h000 |-> ##2 accumulator_pair_o == $past(cmd_i.wdata, 2))
    else $error("accumulator pair wrong");
  AST_REL_RANGE: assert property (tk && op == cpps_pkg::OP_REL && cmd_i.disp[5:1] == 5'h00
    |=> err_o) else $error("bad displacement taken");
  COV_CALL: cover property (tk && op == cpps_pkg::OP_CALL);
  COV_INT_RET: cover property (tk && op == cpps_pkg::OP_RET_INT);
  COV_ERR: cover property (err_o);
endmodule : cpps_core_monitor
bind cpps_core cpps_core_monitor u_mon (.clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
  .cmd_i(cmd_i), .busy_o(busy_o), .program_counter_o(program_counter_o), .rd_valid_o(rd_valid_o),
  .err_o(err_o), .psw_valid_o(psw_valid_o), .accumulator_pair_o(accumulator_pair_o));
`default_nettype wire

// file: sim/cpps_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpps_core_tb_top;
  logic clk_i, reset_i, rom_load_i, cmd_valid_i, ptr_mode, ev, rv, pv;
  logic [10:0] rom_load_addr_i;
  logic [7:0] rom_load_data_i, rd;
  cpps_pkg::cpps_cmd_t cmd_i;
  logic busy_o, rd_valid_o, psw_valid_o, err_o;
  logic [10:0] program_counter_o;
  logic [7:0] fetch_data_o, rd_data_o, psw_o, pointer_register_pair_o, accumulator_pair_o;
  logic [10:0] ra [5] = '{11'h000, 11'h001, 11'h540, 11'h77F, 11'h123};
  logic [7:0] rb [5] = '{8'hFD, 8'h40, 8'h3C, 8'h9E, 8'hA5};
  int n_errors = 0;
  int compares = 0;
  cpps_core DUT (.clk_i(clk_i), .reset_i(reset_i), .rom_load_i(rom_load_i), .rom_load_addr_i(rom_load_addr_i),
    .rom_load_data_i(rom_load_data_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .busy_o(busy_o),
    .program_counter_o(program_counter_o), .fetch_data_o(fetch_data_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .psw_o(psw_o), .psw_valid_o(psw_valid_o), .err_o(err_o),
    .pointer_register_pair_o(pointer_register_pair_o), .accumulator_pair_o(accumulator_pair_o));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic final_report;
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic ck(input logic [11:0] g, input logic [11:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : ck
  // disp rides in target[5:0] and psw in wdata to keep calls short
  task automatic go(input cpps_pkg::cpps_op_t o, input logic [1:0] l, input logic [11:0] a,
      input logic [10:0] t, input logic [7:0] w);
    @(negedge clk_i);
    cmd_i = '{o, l, t, t[5:0], a, ptr_mode, w, w};
    cmd_valid_i = 1'b1;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    ev = err_o;
    rv = rd_valid_o;
    rd = rd_data_o;
    pv = 1'b0;
    for (int i = 0; i < 9 && busy_o !== 1'b0; i++) begin
      @(negedge clk_i);
      pv = pv | (psw_valid_o === 1'b1);
    end
  endtask : go
  task automatic rd4(input logic [11:0] a, input logic [7:0] e);
    go(cpps_pkg::OP_RD4, 2'h1, a, 11'h000, 8'h00);
    ck(rv, 12'h001);
    ck(rd, e);
  endtask : rd4
  task automatic t_boot;
    reset_i = 1'b0;
    for (int i = 0; i < 9 && busy_o !== 1'b0; i++) @(negedge clk_i);
    ck(program_counter_o, 12'h540);
    ck(fetch_data_o, 12'h03C);
  endtask : t_boot
  task automatic t_pc;
    go(cpps_pkg::OP_STEP, 2'h3, 12'h000, 11'h000, 8'h00);
    ck(program_counter_o, 12'h543);
    go(cpps_pkg::OP_BRANCH, 2'h2, 12'h000, 11'h77F, 8'h00);
    ck(fetch_data_o, 12'h09E);
    go(cpps_pkg::OP_BRANCH, 2'h2, 12'h000, 11'h100, 8'h00);
    go(cpps_pkg::OP_REL, 2'h1, 12'h000, 11'h010, 8'h00);
    ck(program_counter_o, 12'h111);
    go(cpps_pkg::OP_REL, 2'h1, 12'h000, 11'h031, 8'h00);
    ck(program_counter_o, 12'h103);
    go(cpps_pkg::OP_REL, 2'h1, 12'h000, 11'h001, 8'h00);
    ck({ev, program_counter_o}, 12'h904);
    go(cpps_pkg::OP_TABLE, 2'h1, 12'h000, 11'h123, 8'h00);
    ck(rd, 12'h0A5);
    go(cpps_pkg::OP_BRANCH, 2'h2, 12'h000, 11'h7FF, 8'h00);
    go(cpps_pkg::OP_STEP, 2'h2, 12'h000, 11'h000, 8'h00);
    ck(program_counter_o, 12'h001);
    ck(fetch_data_o, 12'h040);
  endtask : t_pc
  task automatic t_stack;
    go(cpps_pkg::OP_WR8, 2'h2, 12'hF80, 11'h000, 8'h41);
    go(cpps_pkg::OP_RD8, 2'h2, 12'hF80, 11'h000, 8'h00);
    ck(ev, 12'h001);
    go(cpps_pkg::OP_BRANCH, 2'h2, 12'h000, 11'h2A6, 8'h00);
    go(cpps_pkg::OP_CALL, 2'h2, 12'h000, 11'h100, 8'h00);
    ck(program_counter_o, 12'h100);
    rd4(12'h03F, 8'h0A);
    rd4(12'h03E, 8'h08);
    rd4(12'h03D, 8'h00);
    rd4(12'h03C, 8'h02);
    go(cpps_pkg::OP_RET, 2'h1, 12'h000, 11'h000, 8'h00);
    ck(program_counter_o, 12'h2A8);
    go(cpps_pkg::OP_VECTOR, 2'h1, 12'h000, 11'h050, 8'hC3);
    ck(program_counter_o, 12'h050);
    rd4(12'h03F, 8'h0C);
    // status nibbles rewritten so the restored byte must come from the stack
    go(cpps_pkg::OP_WR8, 2'h2, 12'h03E, 11'h000, 8'h5A);
    go(cpps_pkg::OP_RET_INT, 2'h1, 12'h000, 11'h000, 8'h00);
    ck({pv, program_counter_o}, 12'hAA8);
    ck(psw_o, 12'h05A);
    go(cpps_pkg::OP_CALL, 2'h1, 12'h000, 11'h300, 8'h00);
    go(cpps_pkg::OP_RET_SKIP, 2'h1, 12'h000, 11'h000, 8'h00);
    ck(program_counter_o, 12'h2A9);
  endtask : t_stack
  task automatic t_ram;
    for (int i = 0; i < 32; i++) go(cpps_pkg::OP_WR8, 2'h2, 12'(2 * i), 11'h000, 8'h00);
    rd4(12'h03F, 8'h00);
    go(cpps_pkg::OP_WR8, 2'h2, 12'h003, 11'h000, 8'h25);
    @(negedge clk_i);
    ck(pointer_register_pair_o, 12'h025);
    ptr_mode = 1'b1;
    go(cpps_pkg::OP_WR4, 2'h1, 12'h000, 11'h000, 8'h07);
    ptr_mode = 1'b0;
    rd4(12'h025, 8'h07);
    rd4(12'h002, 8'h05);
    go(cpps_pkg::OP_WR8, 2'h2, 12'h000, 11'h000, 8'h96);
    go(cpps_pkg::OP_RD8, 2'h2, 12'h000, 11'h000, 8'h00);
    ck({rv, rd}, 12'h196);
    ck(accumulator_pair_o, 12'h096);
    go(cpps_pkg::OP_RD4, 2'h1, 12'h040, 11'h000, 8'h00);
    ck({ev, rv}, 12'h002);
    go(cpps_pkg::OP_WR4, 2'h1, 12'hFF0, 11'h000, 8'h03);
    ck(ev, 12'h001);
    go(cpps_pkg::OP_WR4, 2'h1, 12'hF80, 11'h000, 8'h03);
    ck(ev, 12'h001);
  endtask : t_ram
  initial begin
    reset_i = 1'b1;
    rom_load_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    ptr_mode = 1'b0;
    for (int i = 0; i < 16; i++) begin
      rom_load_addr_i = ra[i % 5];
      rom_load_data_i = rb[i % 5];
      @(negedge clk_i);
    end
    rom_load_i = 1'b0;
    t_boot();
    t_pc();
    t_stack();
    t_ram();
    final_report();
  end
  // far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    n_errors++;
    final_report();
  end
endmodule : cpps_core_tb_top
`default_nettype wire
